// ### design/fcr_top.sv
/*
 * Holds the enhanced tone coefficient reload block for oscillator 1.
 * Assumes a classic Wishbone master and an oscillator that takes the
 * coefficient pair whenever OSC_LOAD pulses.
 */
// Added by the designer: the Wishbone interface to the registers.
// How it works
// R1: Enhanced sets used only when both enables set.
// R2: Space expiry loads space amplitude coefficient.
// R3: Space expiry loads space frequency coefficient.
// R4: Mark expiry loads mark amplitude coefficient.
// R5: Mark expiry loads mark frequency coefficient.
// R6: Space-to-mark change scales amplitude by gain.
// R7: Mark-to-space change scales amplitude by gain.
// R8: Host queues next bit; expiry selects set.
`timescale 1ns/1ps
`default_nettype none

module fcr_top (
	input  wire logic              CORE_CLK,
	input  wire logic              RESET,
	input  wire logic              CYC_I,
	input  wire logic              STB_I,
	input  wire logic              WE_I,
	input  wire logic [31:0]       ADR_I,
	input  wire logic [3:0]        SEL_I,
	input  wire logic [31:0]       DAT_I,
	output logic [31:0]            DAT_O,
	output logic                   ACK_O,
	output fcr_pkg::fcr_coef_s     OSC_COEF,
	output logic                   OSC_LOAD,
	output logic                   SYMBOL
);

	// --------------------------------------------------------------------
	// Declarations.
	// --------------------------------------------------------------------
	logic [7:0]  idx;
	logic        req, wr_en, push_req;
	logic        ack_q, ack_d;
	logic [31:0] dat_q, dat_d;
	logic        reload_q, reload_d, enh_q, enh_d;
	logic [15:0] s_amp_q, s_amp_d, s_frq_q, s_frq_d, m_amp_q, m_amp_d, m_frq_q, m_frq_d;
	logic [15:0] s2m_q, s2m_d, m2s_q, m2s_d, n_amp_q, n_amp_d, n_frq_q, n_frq_d;
	logic [15:0] act_q, act_d, tmr_q, tmr_d;
	logic        sym_q, sym_d, load_q, load_d;
	fcr_pkg::fcr_coef_s coef_q, coef_d;
	logic        expiry, enhanced, next_sym;
	logic        f_in_ready, f_out_valid, f_out_ready, f_bit;
	logic [3:0]  f_count;

	// Every check below runs on the core clock and sleeps through reset.
	default clocking cb @(posedge CORE_CLK); endclocking
	default disable iff (RESET);

	// --------------------------------------------------------------------
	// Bus decode.
	// --------------------------------------------------------------------
	assign idx      = ADR_I[9:2];
	assign req      = CYC_I && STB_I && !ack_q;
	assign push_req = req && WE_I && (idx == fcr_pkg::IDX_SYMBOL) && SEL_I[0];
	// A symbol write waits for FIFO room, so back-pressure reaches software.
	assign wr_en    = req && WE_I && (!push_req || f_in_ready);
	assign enhanced = enh_q && reload_q; // see R1

	// Merges the two low byte lanes of a write into a 16-bit register.
	function automatic logic [15:0] lanes(input logic [15:0] old, input logic [3:0] sel,
		input logic [31:0] wd);
		lanes = {sel[1] ? wd[15:8] : old[15:8], sel[0] ? wd[7:0] : old[7:0]};
	endfunction

	// Scales an amplitude by an unsigned gain with 14 fraction bits, saturating.
	function automatic logic [15:0] scale(input logic [15:0] amp, input logic [15:0] g);
		logic [31:0] p;
		p = 32'(amp) * 32'(g);
		scale = (p[31:30] != 2'b00) ? 16'hffff : p[29:fcr_pkg::GAIN_FRAC];
	endfunction

	// --------------------------------------------------------------------
	// Register file: next values.
	// --------------------------------------------------------------------
	always_comb begin
		reload_d = reload_q;
		enh_d    = enh_q;
		s_amp_d  = s_amp_q;
		s_frq_d  = s_frq_q;
		m_amp_d  = m_amp_q;
		m_frq_d  = m_frq_q;
		s2m_d    = s2m_q;
		m2s_d    = m2s_q;
		n_amp_d  = n_amp_q;
		n_frq_d  = n_frq_q;
		act_d    = act_q;
		if (wr_en) begin
			unique case (idx)
				fcr_pkg::IDX_OSC_CTRL: if (SEL_I[0]) reload_d = DAT_I[fcr_pkg::ENABLE_BIT];
				fcr_pkg::IDX_MODE:     if (SEL_I[0]) enh_d = DAT_I[fcr_pkg::ENABLE_BIT];
				fcr_pkg::IDX_SPACE_AMP:  s_amp_d = lanes(s_amp_q, SEL_I, DAT_I);
				fcr_pkg::IDX_SPACE_FREQ: s_frq_d = lanes(s_frq_q, SEL_I, DAT_I);
				fcr_pkg::IDX_MARK_AMP:   m_amp_d = lanes(m_amp_q, SEL_I, DAT_I);
				fcr_pkg::IDX_MARK_FREQ:  m_frq_d = lanes(m_frq_q, SEL_I, DAT_I);
				fcr_pkg::IDX_S2M_GAIN:   s2m_d   = lanes(s2m_q, SEL_I, DAT_I);
				fcr_pkg::IDX_M2S_GAIN:   m2s_d   = lanes(m2s_q, SEL_I, DAT_I);
				fcr_pkg::IDX_OSC_AMP:    n_amp_d = lanes(n_amp_q, SEL_I, DAT_I);
				fcr_pkg::IDX_OSC_FREQ:   n_frq_d = lanes(n_frq_q, SEL_I, DAT_I);
				fcr_pkg::IDX_ACT_TIMER:  act_d   = lanes(act_q, SEL_I, DAT_I);
				default: ;
			endcase
		end
	end

	// Read data and acknowledge; unmapped reads return zero and writes vanish.
	always_comb begin
		ack_d = req && (!push_req || f_in_ready);
		dat_d = 32'h0000_0000;
		if (req && !WE_I) begin
			unique case (idx)
				fcr_pkg::IDX_OSC_CTRL:   dat_d[fcr_pkg::ENABLE_BIT] = reload_q;
				fcr_pkg::IDX_MODE:       dat_d[fcr_pkg::ENABLE_BIT] = enh_q;
				fcr_pkg::IDX_SPACE_AMP:  dat_d[15:0] = s_amp_q;
				fcr_pkg::IDX_SPACE_FREQ: dat_d[15:0] = s_frq_q;
				fcr_pkg::IDX_MARK_AMP:   dat_d[15:0] = m_amp_q;
				fcr_pkg::IDX_MARK_FREQ:  dat_d[15:0] = m_frq_q;
				fcr_pkg::IDX_S2M_GAIN:   dat_d[15:0] = s2m_q;
				fcr_pkg::IDX_M2S_GAIN:   dat_d[15:0] = m2s_q;
				fcr_pkg::IDX_OSC_AMP:    dat_d[15:0] = n_amp_q;
				fcr_pkg::IDX_OSC_FREQ:   dat_d[15:0] = n_frq_q;
				fcr_pkg::IDX_ACT_TIMER:  dat_d[15:0] = act_q;
				fcr_pkg::IDX_SYMBOL:     dat_d[7:0] = {f_count, !f_in_ready, f_out_valid, 1'b0, sym_q};
				default: ;
			endcase
		end
	end

	// Registers the bus side; coefficients start at zero so an early expiry is silent.
	always_ff @(posedge CORE_CLK or posedge RESET) begin
		if (RESET) begin
			ack_q    <= 1'b0;
			dat_q    <= 32'h0000_0000;
			reload_q <= 1'b0;
			enh_q    <= 1'b0;
			s_amp_q  <= fcr_pkg::COEF_RESET;
			s_frq_q  <= fcr_pkg::COEF_RESET;
			m_amp_q  <= fcr_pkg::COEF_RESET;
			m_frq_q  <= fcr_pkg::COEF_RESET;
			s2m_q    <= fcr_pkg::COEF_RESET;
			m2s_q    <= fcr_pkg::COEF_RESET;
			n_amp_q  <= fcr_pkg::COEF_RESET;
			n_frq_q  <= fcr_pkg::COEF_RESET;
			act_q    <= fcr_pkg::TIMER_RESET;
		end else begin
			ack_q    <= ack_d;
			dat_q    <= dat_d;
			reload_q <= reload_d;
			enh_q    <= enh_d;
			s_amp_q  <= s_amp_d;
			s_frq_q  <= s_frq_d;
			m_amp_q  <= m_amp_d;
			m_frq_q  <= m_frq_d;
			s2m_q    <= s2m_d;
			m2s_q    <= m2s_d;
			n_amp_q  <= n_amp_d;
			n_frq_q  <= n_frq_d;
			act_q    <= act_d;
		end
	end

	// --------------------------------------------------------------------
	// Symbol queue; drained only at expiry, so it really fills.
	// --------------------------------------------------------------------
	assign f_out_ready = expiry && enhanced; // see R8

	fcr_fifo #(
		.WIDTH (1),
		.DEPTH (fcr_pkg::FIFO_DEPTH),
		.CW    (fcr_pkg::FIFO_CNT_W)
	) u_fifo (
		.clk       (CORE_CLK),
		.rst       (RESET),
		.in_valid  (push_req),
		.in_ready  (f_in_ready),
		.in_data   (DAT_I[0]),
		.out_valid (f_out_valid),
		.out_ready (f_out_ready),
		.out_data  (f_bit),
		.count     (f_count)
	);

	// --------------------------------------------------------------------
	// Active timer and coefficient reload.
	// --------------------------------------------------------------------
	// An empty queue repeats the last symbol rather than leaving a gap.
	assign expiry   = reload_q && (tmr_q == 16'h0000);
	assign next_sym = f_out_valid ? f_bit : sym_q; // see R8

	// The timer holds its reload value while reload is off, so the first period is whole.
	always_comb begin
		tmr_d  = reload_q ? (expiry ? act_q : tmr_q - 16'h0001) : act_q;
		sym_d  = sym_q;
		coef_d = coef_q;
		load_d = expiry;
		if (expiry) begin
			if (enhanced) begin
				sym_d = next_sym;
				if (next_sym) begin
					coef_d.amplitude = m_amp_q; // see R4
					coef_d.frequency = m_frq_q; // see R5
					if (!sym_q) coef_d.amplitude = scale(m_amp_q, s2m_q); // see R6
				end else begin
					coef_d.amplitude = s_amp_q; // see R2
					coef_d.frequency = s_frq_q; // see R3
					if (sym_q) coef_d.amplitude = scale(s_amp_q, m2s_q); // see R7
				end
			end else begin
				coef_d.amplitude = n_amp_q; // see R1
				coef_d.frequency = n_frq_q;
			end
		end
	end

	// Registers the timer, the current symbol and the pair handed to the oscillator.
	always_ff @(posedge CORE_CLK or posedge RESET) begin
		if (RESET) begin
			tmr_q  <= fcr_pkg::TIMER_RESET;
			sym_q  <= 1'b0;
			coef_q <= '0;
			load_q <= 1'b0;
		end else begin
			tmr_q  <= tmr_d;
			sym_q  <= sym_d;
			coef_q <= coef_d;
			load_q <= load_d;
		end
	end

	// Every output is a flip-flop, so the oscillator never sees decode glitches.
	assign ACK_O    = ack_q;
	assign DAT_O    = dat_q;
	assign OSC_COEF = coef_q;
	assign OSC_LOAD = load_q;
	assign SYMBOL   = sym_q;

	// --------------------------------------------------------------------
	// Assertions.
	// --------------------------------------------------------------------
	// Bus handshake: a one-cycle answer and a quiet data bus between answers.
	a_ack_single_pulse: assert property (ACK_O |=> !ACK_O)
		else $error("ack held for more than one cycle");
	a_normal_load_set: assert property (expiry && !enhanced |=> // see R1
		OSC_LOAD && OSC_COEF.amplitude == $past(n_amp_q) && OSC_COEF.frequency == $past(n_frq_q))
		else $error("normal coefficients not loaded outside enhanced mode");
	a_space_amp_load: assert property (f_out_ready && !next_sym && !sym_q |=> // see R2
		OSC_COEF.amplitude == $past(s_amp_q))
		else $error("space amplitude not loaded");
	a_space_freq_load: assert property (f_out_ready && !next_sym |=> // see R3
		OSC_COEF.frequency == $past(s_frq_q) && !SYMBOL)
		else $error("space frequency not loaded");
	a_mark_amp_load: assert property (f_out_ready && next_sym && sym_q |=> // see R4
		OSC_COEF.amplitude == $past(m_amp_q))
		else $error("mark amplitude not loaded");
	a_mark_freq_load: assert property (f_out_ready && next_sym |=> // see R5
		OSC_COEF.frequency == $past(m_frq_q) && SYMBOL)
		else $error("mark frequency not loaded");
	a_gain_space_mark: assert property (f_out_ready && next_sym && !sym_q |=> // see R6
		OSC_COEF.amplitude == scale($past(m_amp_q), $past(s2m_q)))
		else $error("space to mark gain not applied");
	a_gain_mark_space: assert property (f_out_ready && !next_sym && sym_q |=> // see R7
		OSC_COEF.amplitude == scale($past(s_amp_q), $past(m2s_q)))
		else $error("mark to space gain not applied");
	a_queued_bit_used: assert property (f_out_ready && f_out_valid |=> // see R8
		SYMBOL == $past(f_bit) && OSC_LOAD)
		else $error("queued bit not used at expiry");
	a_timer_period: assert property (expiry && act_q == 16'h0003 && reload_q |=>
		!expiry ##1 !expiry ##1 !expiry ##1 (expiry || !reload_q || act_q != 16'h0003))
		else $error("active timer period wrong");

	// A request that needs no queue room is answered in the next cycle.
	a_ack_next_cycle: assert property (CYC_I && STB_I && !ACK_O && !push_req |=> ACK_O)
		else $error("request not answered in the next cycle");
	// A symbol write into a full queue waits rather than being lost.
	a_full_stalls_ack: assert property (push_req && !f_in_ready |=> !ACK_O) // see R8
		else $error("symbol write answered while the queue was full");
	a_read_idle_zero: assert property (!ACK_O |-> DAT_O == 32'h0000_0000)
		else $error("read data not zero outside an answer");

	// Oscillator side: one load per expiry, and nothing enhanced without both enables.
	a_load_per_expiry: assert property (OSC_LOAD == $past(expiry))
		else $error("load pulse not one cycle after expiry");
	a_symbol_held_normal: assert property (!(expiry && enhanced) |=> // see R1
		$stable(SYMBOL))
		else $error("symbol changed outside an enhanced expiry");
	a_queue_kept_normal: assert property (expiry && !enhanced |=> // see R1
		f_count >= $past(f_count))
		else $error("queue drained outside enhanced mode");
	a_empty_repeats_symbol: assert property (f_out_ready && !f_out_valid |=> // see R8
		SYMBOL == $past(sym_q))
		else $error("empty queue did not repeat the symbol");
	a_queue_bounded: assert property (f_count <= 4'(fcr_pkg::FIFO_DEPTH))
		else $error("queue count beyond its depth");

	c_empty_repeat: cover property (f_out_ready && !f_out_valid);
	c_space_to_mark: cover property (f_out_ready && next_sym && !sym_q);
	c_mark_to_space: cover property (f_out_ready && !next_sym && sym_q);
	c_fifo_full: cover property (!f_in_ready && push_req);
	c_normal_reload: cover property (expiry && !enhanced);

endmodule

`default_nettype wire

// ### design/fcr_pkg.sv
/*
 * Holds the constants and carrier types of the tone coefficient reload block.
 * Assumes a 32-bit classic Wishbone bus whose word index is ADR_I[9:2].
 */
package fcr_pkg;

	// --------------------------------------------------------------------
	// Register indexes; the byte address is four times the index.
	// --------------------------------------------------------------------
	localparam logic [7:0] IDX_OSC_CTRL    = 8'h20; // Bit 6 enables oscillator reload.
	localparam logic [7:0] IDX_SPACE_AMP   = 8'h45;
	localparam logic [7:0] IDX_SPACE_FREQ  = 8'h46;
	localparam logic [7:0] IDX_MARK_AMP    = 8'h47;
	localparam logic [7:0] IDX_MARK_FREQ   = 8'h48;
	localparam logic [7:0] IDX_S2M_GAIN    = 8'h49;
	localparam logic [7:0] IDX_M2S_GAIN    = 8'h4a;
	localparam logic [7:0] IDX_OSC_AMP     = 8'h50;
	localparam logic [7:0] IDX_OSC_FREQ    = 8'h51;
	localparam logic [7:0] IDX_ACT_TIMER   = 8'h52;
	localparam logic [7:0] IDX_SYMBOL      = 8'h53; // Write pushes a bit, read shows state.
	localparam logic [7:0] IDX_MODE        = 8'h6c; // Bit 6 enables the enhanced mode.

	// --------------------------------------------------------------------
	// Field positions, widths and reset values.
	// --------------------------------------------------------------------
	localparam int         ENABLE_BIT      = 6;
	localparam int         COEF_W          = 16;
	localparam int         FIFO_DEPTH      = 8;
	localparam int         FIFO_CNT_W      = 4;
	localparam int         GAIN_FRAC       = 14;    // Gain of 16'h4000 is unity.
	localparam logic [15:0] COEF_RESET     = 16'h0000;
	localparam logic [15:0] TIMER_RESET    = 16'h0000;

	// Coefficient pair that is handed to oscillator 1 at each expiry.
	typedef struct packed {
		logic [15:0] amplitude;
		logic [15:0] frequency;
	} fcr_coef_s;

endpackage

// ### design/fcr_fifo.sv
/*
 * Holds a small synchronous FIFO with valid and ready on both sides.
 * Assumes one clock and an asynchronous active-high reset.
 */
`timescale 1ns/1ps
`default_nettype none

module fcr_fifo #(
	parameter int WIDTH = 1,
	parameter int DEPTH = 8,
	parameter int CW    = 4
) (
	input  wire logic             clk,
	input  wire logic             rst,
	input  wire logic             in_valid,
	output logic                  in_ready,
	input  wire logic [WIDTH-1:0] in_data,
	output logic                  out_valid,
	input  wire logic             out_ready,
	output logic [WIDTH-1:0]      out_data,
	output logic [CW-1:0]         count
);

	// --------------------------------------------------------------------
	// Storage and pointers.
	// --------------------------------------------------------------------
	logic [WIDTH-1:0] mem_q [DEPTH];
	logic [CW-1:0]    wr_q, wr_d, rd_q, rd_d, cnt_q, cnt_d;
	logic             push, pop;

	// Full and empty come straight from the occupancy count.
	assign in_ready  = (cnt_q != CW'(DEPTH));
	assign out_valid = (cnt_q != '0);
	assign out_data  = mem_q[rd_q[$clog2(DEPTH)-1:0]];
	assign count     = cnt_q;
	assign push      = in_valid && in_ready;
	assign pop       = out_valid && out_ready;

	// Pointers wrap at the depth so any depth works.
	always_comb begin
		wr_d  = push ? ((wr_q == CW'(DEPTH - 1)) ? '0 : wr_q + CW'(1)) : wr_q;
		rd_d  = pop ? ((rd_q == CW'(DEPTH - 1)) ? '0 : rd_q + CW'(1)) : rd_q;
		cnt_d = cnt_q + CW'(push) - CW'(pop);
	end

	// Registers only; the storage array has no reset to stay small.
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			wr_q  <= '0;
			rd_q  <= '0;
			cnt_q <= '0;
		end else begin
			wr_q  <= wr_d;
			rd_q  <= rd_d;
			cnt_q <= cnt_d;
		end
	end

	always_ff @(posedge clk) begin
		if (push) begin
			mem_q[wr_q[$clog2(DEPTH)-1:0]] <= in_data;
		end
	end

endmodule

`default_nettype wire

// ### tb/test_fcr_top.sv
/*
 * Self-checking bench for the tone coefficient reload block.
 * Assumes the design package and top module are compiled first; the bench
 * alone masters the Wishbone port and watches the oscillator outputs.
 */
`timescale 1ns/1ps
`default_nettype none

module test_fcr_top;

	// ------------------------------------------------------------------
	// Signals
	// ------------------------------------------------------------------
	logic               CORE_CLK   = 1'b0;
	logic               RESET      = 1'b1;
	logic               CYC_I      = 1'b0;
	logic               STB_I      = 1'b0;
	logic               WE_I       = 1'b0;
	logic [31:0]        ADR_I      = 32'h0000_0000;
	logic [3:0]         SEL_I      = 4'hf;
	logic [31:0]        DAT_I      = 32'h0000_0000;
	logic [31:0]        DAT_O;
	logic               ACK_O;
	logic               OSC_LOAD;
	logic               SYMBOL;
	fcr_pkg::fcr_coef_s OSC_COEF;
	int                 bad_count  = 0;
	int                 num_checks = 0;
	int                 cyc_n      = 0;
	logic [32:0]        cap[$];
	int                 cap_t[$];
	logic [31:0]        d;

	fcr_top dut (.CORE_CLK(CORE_CLK), .RESET(RESET), .CYC_I(CYC_I), .STB_I(STB_I),
		.WE_I(WE_I), .ADR_I(ADR_I), .SEL_I(SEL_I), .DAT_I(DAT_I), .DAT_O(DAT_O),
		.ACK_O(ACK_O), .OSC_COEF(OSC_COEF), .OSC_LOAD(OSC_LOAD), .SYMBOL(SYMBOL));

	// Clock at 100 MHz.
	always #5 CORE_CLK = ~CORE_CLK;

	// Every load is logged with its cycle, so spacing can be judged later.
	always @(posedge CORE_CLK) begin
		cyc_n <= cyc_n + 1;
		if (OSC_LOAD === 1'b1) begin
			cap.push_back({SYMBOL, OSC_COEF});
			cap_t.push_back(cyc_n);
		end
	end

	// ------------------------------------------------------------------
	// Tasks
	// ------------------------------------------------------------------
	task automatic close_out();
		if (bad_count == 0 && num_checks > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask

	task automatic chk(input string what, input logic [32:0] exp, input logic [32:0] got);
		num_checks++;
		if (got !== exp) begin
			bad_count++;
			$display("unexpected %s: expected %h seen %h", what, exp, got);
		end
	endtask

	// One classic cycle; the request stands until ack is sampled high.
	task automatic wb(input logic we, input logic [7:0] idx, input logic [31:0] wd,
		output logic [31:0] rd);
		int n;
		@(posedge CORE_CLK);
		CYC_I <= 1'b1;
		STB_I <= 1'b1;
		WE_I  <= we;
		ADR_I <= {22'h000000, idx, 2'b00};
		DAT_I <= wd;
		for (n = 0; n < 200; n++) begin
			@(posedge CORE_CLK);
			if (ACK_O === 1'b1) break;
		end
		rd = DAT_O;
		CYC_I <= 1'b0;
		STB_I <= 1'b0;
		WE_I  <= 1'b0;
		if (n == 200) begin
			bad_count++;
			close_out();
		end
	endtask

	task automatic wr(input logic [7:0] idx, input logic [31:0] wd);
		logic [31:0] x;
		wb(1'b1, idx, wd, x);
	endtask

	// Waits a bounded time for a given number of logged loads.
	task automatic wait_loads(input int k);
		int n;
		for (n = 0; n < 400 && cap.size() < k; n++) @(posedge CORE_CLK);
		if (cap.size() < k) begin
			bad_count++;
			close_out();
		end
	endtask

	// Unsigned 2.14 gain, saturating to the full 16-bit range.
	function automatic logic [15:0] scale(input logic [15:0] a, input logic [15:0] g);
		logic [31:0] p;
		p = ({16'h0000, a} * {16'h0000, g}) >> 14;
		return (p > 32'h0000_ffff) ? 16'hffff : p[15:0];
	endfunction

	// ------------------------------------------------------------------
	// Sequence
	// ------------------------------------------------------------------
	logic [15:0] cv[6] = '{16'h1234, 16'h0ccc, 16'h9000, 16'h0bbb, 16'h8000, 16'h2000};
	logic [32:0] ex[5];
	int          i;

	initial begin
		repeat (16) @(posedge CORE_CLK);
		RESET <= 1'b0;
		chk("coef out at reset", 33'h0, {SYMBOL, OSC_COEF});
		// Coefficients start at zero, then hold what is written.
		for (i = 0; i < 6; i++) begin
			wb(1'b0, 8'h45 + 8'(i), 32'h0, d);
			chk("coef reset", 33'h0, {1'b0, d});
			wr(8'h45 + 8'(i), {16'h0000, cv[i]});
			wb(1'b0, 8'h45 + 8'(i), 32'h0, d);
			chk("coef readback", {17'h0, cv[i]}, {1'b0, d});
		end
		// An unmapped place reads zero and ignores writes.
		wr(8'h7f, 32'h0000_5a5a);
		wb(1'b0, 8'h7f, 32'h0, d);
		chk("unmapped read", 33'h0, {1'b0, d});
		wr(fcr_pkg::IDX_OSC_AMP, 32'h0000_1111);
		wr(fcr_pkg::IDX_OSC_FREQ, 32'h0000_2222);
		wr(fcr_pkg::IDX_ACT_TIMER, 32'h0000_0003);
		// Reload without the enhanced mode keeps the normal pair, queue untouched.
		wr(fcr_pkg::IDX_SYMBOL, 32'h0000_0001);
		cap.delete();
		cap_t.delete();
		wr(fcr_pkg::IDX_OSC_CTRL, 32'h0000_0040);
		wait_loads(2);
		chk("normal load", {1'b0, 16'h1111, 16'h2222}, cap[0]);
		chk("load spacing", 33'd4, 33'(cap_t[1] - cap_t[0]));
		wr(fcr_pkg::IDX_OSC_CTRL, 32'h0000_0000);
		repeat (2) @(posedge CORE_CLK);
		cap.delete();
		repeat (20) @(posedge CORE_CLK);
		chk("loads with reload off", 33'h0, 33'(cap.size()));
		wb(1'b0, fcr_pkg::IDX_SYMBOL, 32'h0, d);
		chk("queue kept", 33'h14, {1'b0, d});
		// Mode alone does nothing until reload is set as well.
		wr(fcr_pkg::IDX_SYMBOL, 32'h0000_0001);
		wr(fcr_pkg::IDX_SYMBOL, 32'h0000_0000);
		wr(fcr_pkg::IDX_SYMBOL, 32'h0000_0000);
		wr(fcr_pkg::IDX_MODE, 32'h0000_0040);
		repeat (10) @(posedge CORE_CLK);
		chk("mode alone", 33'h0, 33'(cap.size()));
		// Queue 1,1,0,0 then empty: both gains, saturation, repeat.
		ex[0] = {1'b1, scale(cv[2], cv[4]), cv[3]};
		ex[1] = {1'b1, cv[2], cv[3]};
		ex[2] = {1'b0, scale(cv[0], cv[5]), cv[1]};
		ex[3] = {1'b0, cv[0], cv[1]};
		ex[4] = {1'b0, cv[0], cv[1]};
		wr(fcr_pkg::IDX_OSC_CTRL, 32'h0000_0040);
		wait_loads(5);
		wr(fcr_pkg::IDX_OSC_CTRL, 32'h0000_0000);
		chk("space to mark", ex[0], cap[0]);
		chk("mark steady", ex[1], cap[1]);
		chk("mark to space", ex[2], cap[2]);
		chk("space steady", ex[3], cap[3]);
		chk("empty repeat", ex[4], cap[4]);
		// Fill the queue to its depth and read the status.
		repeat (2) @(posedge CORE_CLK);
		for (i = 0; i < fcr_pkg::FIFO_DEPTH; i++) begin
			wr(fcr_pkg::IDX_SYMBOL, 32'(i % 2));
		end
		wb(1'b0, fcr_pkg::IDX_SYMBOL, 32'h0, d);
		chk("queue full", 33'h8c, {1'b0, d});
		// One bit more than the queue holds is answered only once an expiry frees room.
		cap.delete();
		wr(fcr_pkg::IDX_OSC_CTRL, 32'h0000_0040);
		wr(fcr_pkg::IDX_SYMBOL, 32'h0000_0001);
		wait_loads(1);
		chk("drain after full", {1'b0, cv[0], cv[1]}, cap[0]);
		close_out();
	end

endmodule

`default_nettype wire
